// ===== pxs_pkg.sv
// Purpose: Shared constants for the proximity sensor serial port and its host
// Assumes: 25 MHz pclk, 7-bit bus addressing
// Notes: Register map of the sensor and of the host controller
// ****************************************
// Package
// ****************************************
package pxs_pkg;
	// Bus timing
	localparam int CLK_PERIOD_NS = 40;
	localparam int SCL_PERIOD_NS = 10000;
	localparam int QUARTER_CYCLES = SCL_PERIOD_NS / 4 / CLK_PERIOD_NS;
	// Sensor bus address and transfer address bytes
	localparam logic [6:0] DEV_ADDR7 = 7'h13;
	localparam logic [7:0] WR_ADDR_BYTE = {DEV_ADDR7, 1'b0};
	localparam logic [7:0] RD_ADDR_BYTE = {DEV_ADDR7, 1'b1};
	// Sensor register map
	localparam logic [3:0] REG_BANK = 4'h8;
	localparam logic [7:0] REG_LED_CURRENT = 8'h83;
	localparam logic [7:0] REG_PROX_HI = 8'h87;
	localparam logic [7:0] REG_PROX_LO = 8'h88;
	localparam logic [7:0] REG_MOD_TIMING = 8'h8F;
	localparam logic [7:0] REG_AMBIENT_IR = 8'h90;
	localparam logic [7:0] MOD_TIMING_DEFAULT = 8'h01;
	localparam int REG_COUNT = 16;
	// Host controller APB map
	localparam logic [11:0] APB_CMD = 12'h000;
	localparam logic [11:0] APB_STATUS = 12'h004;
	localparam logic [11:0] APB_RDATA = 12'h008;
	// Command fields
	localparam int CMD_REG_LSB = 0;
	localparam int CMD_WDATA_LSB = 8;
	localparam int CMD_LEN_LSB = 16;
	localparam int CMD_WRITE_BIT = 18;
	localparam int CMD_RSTART_BIT = 19;
	localparam int CMD_TIMING_BIT = 20;
	// Status fields
	localparam int ST_BUSY_BIT = 0;
	localparam int ST_DONE_BIT = 1;
	localparam int ST_NACK_BIT = 2;
	localparam int ST_REFUSED_BIT = 3;

	// Register held in the sensor's writable bank
	function automatic logic pxs_in_bank(input logic [7:0] a);
		return a[7:4] == REG_BANK;
	endfunction : pxs_in_bank

	// Writable bank entry, result bytes excluded
	function automatic logic pxs_writable(input logic [7:0] a);
		return pxs_in_bank(a) && a != REG_PROX_HI && a != REG_PROX_LO;
	endfunction : pxs_writable

	// Mapped host register offset
	function automatic logic pxs_apb_mapped(input logic [11:0] a);
		return a == APB_CMD || a == APB_STATUS || a == APB_RDATA;
	endfunction : pxs_apb_mapped
endpackage : pxs_pkg

// ===== pxs_i2c_if.sv
// Purpose: Two-wire bus between sensor and host
// Assumes: Open-drain lines with pull-ups
// Notes: Line levels resolved from the enables here
`timescale 1ns/100ps
// ****************************************
// Interface
// ****************************************
interface pxs_i2c_if;
	logic host_scl_o;
	logic host_scl_oe;
	logic host_sda_o;
	logic host_sda_oe;
	logic dev_sda_o;
	logic dev_sda_oe;
	logic scl;
	logic sda;

	// Wired-AND with pull-up
	assign scl = !(host_scl_oe && !host_scl_o);
	assign sda = !((host_sda_oe && !host_sda_o) || (dev_sda_oe && !dev_sda_o));

	modport host (output host_scl_o, output host_scl_oe, output host_sda_o,
		output host_sda_oe, input scl, input sda);
	modport device (output dev_sda_o, output dev_sda_oe, input scl, input sda);
endinterface : pxs_i2c_if

// ===== pxs_device.sv
// Purpose: Sensor serial slave with register pointer and standby control
// Assumes: Host drives scl, no clock stretching
// Notes: Measurement engine is outside; result enters on prox_result
`timescale 1ns/100ps
// ****************************************
// Sensor serial slave
// ****************************************
module pxs_device (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	pxs_i2c_if.device bus,
	input wire logic measure_req,
	input wire logic [15:0] prox_result,
	input wire logic [7:0] ambient_ir,
	output logic standby,
	output logic led_sink_en,
	output logic [7:0] led_current
);
	typedef enum logic [2:0] {D_IDLE, D_ADDR, D_ACK, D_WR, D_RD, D_RACK} pxs_dstate_type;

	pxs_dstate_type state_q;
	logic scl_m_q, scl_s_q, scl_p_q;
	logic sda_m_q, sda_s_q, sda_p_q;
	logic [3:0] cnt_q;
	logic [7:0] rx_q;
	logic [7:0] tx_q;
	logic [7:0] ptr_q;
	logic rw_q;
	logic first_q;
	localparam int REG_COUNT = pxs_pkg::REG_COUNT;
	logic [7:0] mem_q [REG_COUNT];
	logic [7:0] rd_byte;
	logic scl_rise, scl_fall, start_c, stop_c, byte_done, wr_store;
	logic standby_q, sink_q;

	// ****************************************
	// Line synchronisers
	// ****************************************
	// Two stages then an edge stage
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			{scl_m_q, scl_s_q, scl_p_q} <= 3'h7;
			{sda_m_q, sda_s_q, sda_p_q} <= 3'h7;
		end else if (clk_en) begin
			{scl_m_q, scl_s_q, scl_p_q} <= {bus.scl, scl_m_q, scl_s_q};
			{sda_m_q, sda_s_q, sda_p_q} <= {bus.sda, sda_m_q, sda_s_q};
		end
	end

	// Bus events
	assign scl_rise = scl_s_q && !scl_p_q;
	assign scl_fall = !scl_s_q && scl_p_q;
	assign start_c = scl_s_q && scl_p_q && !sda_s_q && sda_p_q;
	assign stop_c = scl_s_q && scl_p_q && sda_s_q && !sda_p_q;
	assign byte_done = scl_fall && cnt_q == 4'h8;
	assign wr_store = state_q == D_WR && byte_done && !first_q && pxs_pkg::pxs_writable(ptr_q);

	// ****************************************
	// Register read mux
	// ****************************************
	// Byte served at the pointer
	always_comb begin
		rd_byte = 8'h00;
		if (ptr_q == pxs_pkg::REG_PROX_HI) begin
			rd_byte = prox_result[15:8];
		end else if (ptr_q == pxs_pkg::REG_PROX_LO) begin
			rd_byte = prox_result[7:0];
		end else if (ptr_q == pxs_pkg::REG_AMBIENT_IR) begin
			rd_byte = ambient_ir;
		end else if (pxs_pkg::pxs_in_bank(ptr_q)) begin
			rd_byte = mem_q[ptr_q[3:0]];
		end
	end

	// ****************************************
	// Slave sequencer
	// ****************************************
	// Port stays live in standby
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= D_IDLE;
			cnt_q <= 4'h0;
			rx_q <= 8'h00;
			tx_q <= 8'hFF;
			ptr_q <= 8'h00;
			rw_q <= 1'b0;
			first_q <= 1'b1;
		end else if (clk_en) begin
			if (start_c) begin
				// Start or repeated start, pointer kept
				state_q <= D_ADDR;
				cnt_q <= 4'h0;
				rw_q <= 1'b0;
				first_q <= 1'b1;
			end else if (stop_c) begin
				state_q <= D_IDLE;
			end else begin
				unique case (state_q)
					D_IDLE: begin
						cnt_q <= 4'h0;
					end
					D_ADDR, D_WR: begin
						if (scl_rise) begin
							rx_q <= {rx_q[6:0], sda_s_q};
							cnt_q <= cnt_q + 4'h1;
						end else if (byte_done) begin
							cnt_q <= 4'h0;
							if (state_q == D_ADDR) begin
								if (rx_q[7:1] == pxs_pkg::DEV_ADDR7) begin
									state_q <= D_ACK;
									rw_q <= rx_q[0];
								end else begin
									state_q <= D_IDLE;
								end
							end else begin
								state_q <= D_ACK;
								first_q <= 1'b0;
								ptr_q <= first_q ? rx_q : ptr_q + 8'h01;
							end
						end
					end
					D_ACK: begin
						if (scl_fall) begin
							state_q <= rw_q ? D_RD : D_WR;
							tx_q <= rd_byte;
						end
					end
					D_RD: begin
						if (scl_rise) begin
							cnt_q <= cnt_q + 4'h1;
						end else if (byte_done) begin
							state_q <= D_RACK;
							cnt_q <= 4'h0;
							ptr_q <= ptr_q + 8'h01;
						end else if (scl_fall) begin
							tx_q <= {tx_q[6:0], 1'b1};
						end
					end
					D_RACK: begin
						if (scl_rise && sda_s_q) begin
							state_q <= D_IDLE; // Host declined more
						end else if (scl_fall) begin
							state_q <= D_RD;
							tx_q <= rd_byte;
						end
					end
				endcase
			end
		end
	end

	// Writable register bank
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < REG_COUNT; i++) begin
				mem_q[i] <= 8'h00;
			end
			mem_q[pxs_pkg::REG_MOD_TIMING[3:0]] <= pxs_pkg::MOD_TIMING_DEFAULT;
		end else if (clk_en && wr_store) begin
			mem_q[ptr_q[3:0]] <= rx_q;
		end
	end

	// Standby and emitter sink
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			standby_q <= 1'b1;
			sink_q <= 1'b0;
		end else if (clk_en) begin
			standby_q <= !measure_req;
			sink_q <= measure_req;
		end
	end

	// Outputs
	assign standby = standby_q;
	assign led_sink_en = sink_q;
	assign led_current = mem_q[pxs_pkg::REG_LED_CURRENT[3:0]];
	assign bus.dev_sda_o = 1'b0;
	assign bus.dev_sda_oe = state_q == D_ACK || (state_q == D_RD && !tx_q[7]);
endmodule : pxs_device

// ===== pxs_host.sv
// Purpose: Bus host controller that reads and writes sensor registers
// Assumes: APB slave for software, 25 MHz pclk
// Notes: One command at a time, up to four read bytes
// Function
// - Sensor idles in standby unless measuring
// - Emitter sink off during standby
// - Address write without data, then read
// - Read returns the addressed register
// - Stop or repeated start both accepted
// - Pointer advances after every read byte
// - Write byte 26h, read byte 27h
// - Result high 87h, low 88h
// - Program modulator timing to value 1
// - Never access ambient register 90h (only commands naming 90h are refused; a burst read can reach it)
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/100ps
// ****************************************
// Host controller
// ****************************************
module pxs_host #(
	parameter int QUARTER = pxs_pkg::QUARTER_CYCLES
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	pxs_i2c_if.host bus
);
	typedef enum logic [3:0] {
		H_IDLE, H_START, H_ADDRW, H_REG, H_WDATA, H_MSTOP, H_ADDRR, H_READ, H_STOP
	} pxs_hstate_type;

	pxs_hstate_type state_q;
	logic [15:0] div_q;
	logic [1:0] qtr_q;
	logic [3:0] bit_q;
	logic [7:0] tx_q;
	logic [7:0] rx_q;
	logic [1:0] byte_q;
	logic [1:0] len_q;
	logic [7:0] reg_q;
	logic [7:0] wdata_q;
	logic wr_q, rstart_q, rd_phase_q, ack_ok_q;
	logic done_q, nack_q, refused_q;
	logic [31:0] rdata_q;
	logic [31:0] prdata_q;
	logic scl_hi_q, sda_hi_q;
	logic sda_m_q, sda_s_q;
	logic busy, tick, is_byte, is_write, last_bit, elem_end;
	logic apb_wr, cmd_wr, st_wr, cmd_bad;
	logic [7:0] cmd_reg;

	// ****************************************
	// APB slave
	// ****************************************
	// Zero wait states, error on unmapped offset
	assign pready = 1'b1;
	assign pslverr = psel && penable && !pxs_pkg::pxs_apb_mapped(paddr);
	assign prdata = prdata_q;
	assign apb_wr = psel && penable && pwrite;
	assign cmd_wr = apb_wr && paddr == pxs_pkg::APB_CMD;
	assign st_wr = apb_wr && paddr == pxs_pkg::APB_STATUS;
	assign cmd_reg = pwdata[pxs_pkg::CMD_TIMING_BIT] ? pxs_pkg::REG_MOD_TIMING :
		pwdata[pxs_pkg::CMD_REG_LSB +: 8];
	// Busy or forbidden register refuses the command
	assign cmd_bad = busy || cmd_reg == pxs_pkg::REG_AMBIENT_IR;

	// Read data latched in the setup cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= 32'h0000_0000;
		end else if (clk_en && psel && !penable && !pwrite) begin
			if (paddr == pxs_pkg::APB_STATUS) begin
				prdata_q <= 32'h0000_0000;
				prdata_q[pxs_pkg::ST_BUSY_BIT] <= busy;
				prdata_q[pxs_pkg::ST_DONE_BIT] <= done_q;
				prdata_q[pxs_pkg::ST_NACK_BIT] <= nack_q;
				prdata_q[pxs_pkg::ST_REFUSED_BIT] <= refused_q;
			end else if (paddr == pxs_pkg::APB_RDATA) begin
				prdata_q <= rdata_q;
			end else begin
				prdata_q <= 32'h0000_0000;
			end
		end
	end

	// ****************************************
	// Bit timing
	// ****************************************
	assign busy = state_q != H_IDLE;
	assign tick = busy && div_q == 16'(QUARTER - 1);
	assign is_byte = state_q inside {H_ADDRW, H_REG, H_WDATA, H_ADDRR, H_READ};
	assign is_write = state_q inside {H_ADDRW, H_REG, H_WDATA, H_ADDRR};
	assign last_bit = bit_q == 4'h8;
	assign elem_end = tick && qtr_q == 2'h3 && (!is_byte || last_bit);

	// Quarter-period divider
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_q <= 16'h0000;
			qtr_q <= 2'h0;
		end else if (clk_en) begin
			if (!busy || tick) begin
				div_q <= 16'h0000;
			end else begin
				div_q <= div_q + 16'h0001;
			end
			if (!busy) begin
				qtr_q <= 2'h0;
			end else if (tick) begin
				qtr_q <= qtr_q + 2'h1;
			end
		end
	end

	// Data line synchroniser
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sda_m_q <= 1'b1;
			sda_s_q <= 1'b1;
		end else if (clk_en) begin
			sda_m_q <= bus.sda;
			sda_s_q <= sda_m_q;
		end
	end

	// ****************************************
	// Line drive
	// ****************************************
	// Levels per quarter of each bus element
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			scl_hi_q <= 1'b1;
			sda_hi_q <= 1'b1;
		end else if (clk_en) begin
			if (!busy) begin
				scl_hi_q <= 1'b1;
				sda_hi_q <= 1'b1;
			end else if (tick) begin
				unique case (qtr_q)
					2'h0: begin
						if (state_q == H_START) begin
							sda_hi_q <= 1'b1;
						end else if (state_q == H_MSTOP || state_q == H_STOP) begin
							sda_hi_q <= 1'b0;
						end else if (state_q == H_READ) begin
							// Last byte left unacknowledged
							sda_hi_q <= last_bit ? byte_q == len_q : 1'b1;
						end else begin
							sda_hi_q <= last_bit ? 1'b1 : tx_q[7];
						end
					end
					2'h1: begin
						scl_hi_q <= 1'b1;
					end
					2'h2: begin
						if (state_q == H_START) begin
							sda_hi_q <= 1'b0;
						end else if (state_q == H_MSTOP || state_q == H_STOP) begin
							sda_hi_q <= 1'b1;
						end
					end
					2'h3: begin
						if (state_q != H_MSTOP && state_q != H_STOP) begin
							scl_hi_q <= 1'b0;
						end
					end
				endcase
			end
		end
	end

	// ****************************************
	// Transfer sequencer
	// ****************************************
	// Command, bytes and status flags; set wins over clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= H_IDLE;
			bit_q <= 4'h0;
			tx_q <= 8'hFF;
			rx_q <= 8'h00;
			byte_q <= 2'h0;
			len_q <= 2'h0;
			reg_q <= 8'h00;
			wdata_q <= 8'h00;
			wr_q <= 1'b0;
			rstart_q <= 1'b0;
			rd_phase_q <= 1'b0;
			ack_ok_q <= 1'b0;
			done_q <= 1'b0;
			nack_q <= 1'b0;
			refused_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
		end else if (clk_en) begin
			// Write one to clear
			if (st_wr) begin
				done_q <= done_q && !pwdata[pxs_pkg::ST_DONE_BIT];
				nack_q <= nack_q && !pwdata[pxs_pkg::ST_NACK_BIT];
				refused_q <= refused_q && !pwdata[pxs_pkg::ST_REFUSED_BIT];
			end
			if (cmd_wr && cmd_bad) begin
				refused_q <= 1'b1;
			end
			// Bit shifting within a byte
			if (tick && is_byte && qtr_q == 2'h2) begin
				if (is_write && last_bit) begin
					ack_ok_q <= !sda_s_q;
				end else if (!is_write && !last_bit) begin
					rx_q <= {rx_q[6:0], sda_s_q};
				end
			end
			if (tick && is_byte && qtr_q == 2'h3) begin
				bit_q <= last_bit ? 4'h0 : bit_q + 4'h1;
				if (!last_bit) begin
					tx_q <= {tx_q[6:0], 1'b1};
				end
			end
			unique case (state_q)
				H_IDLE: begin
					if (cmd_wr && !cmd_bad) begin
						state_q <= H_START;
						reg_q <= cmd_reg;
						// Recommended modulator timing
						wdata_q <= pwdata[pxs_pkg::CMD_TIMING_BIT] ?
							pxs_pkg::MOD_TIMING_DEFAULT : pwdata[pxs_pkg::CMD_WDATA_LSB +: 8];
						wr_q <= pwdata[pxs_pkg::CMD_WRITE_BIT] || pwdata[pxs_pkg::CMD_TIMING_BIT];
						rstart_q <= pwdata[pxs_pkg::CMD_RSTART_BIT];
						len_q <= pwdata[pxs_pkg::CMD_LEN_LSB +: 2];
						rd_phase_q <= 1'b0;
						bit_q <= 4'h0;
						byte_q <= 2'h0;
						done_q <= 1'b0;
						nack_q <= 1'b0;
						rdata_q <= 32'h0000_0000;
					end
				end
				H_START: begin
					if (elem_end) begin
						state_q <= rd_phase_q ? H_ADDRR : H_ADDRW;
						tx_q <= rd_phase_q ? pxs_pkg::RD_ADDR_BYTE : pxs_pkg::WR_ADDR_BYTE;
					end
				end
				H_ADDRW, H_REG, H_ADDRR: begin
					if (elem_end && !ack_ok_q) begin
						state_q <= H_STOP;
						nack_q <= 1'b1;
					end else if (elem_end && state_q == H_ADDRW) begin
						state_q <= H_REG;
						tx_q <= reg_q;
					end else if (elem_end && state_q == H_REG) begin
						// Data byte if writing, else data-less write, then read
						rd_phase_q <= 1'b1;
						tx_q <= wdata_q;
						if (wr_q) begin
							state_q <= H_WDATA;
						end else begin
							state_q <= rstart_q ? H_START : H_MSTOP;
						end
					end else if (elem_end) begin
						state_q <= H_READ;
						byte_q <= 2'h0;
					end
				end
				H_WDATA: begin
					if (elem_end) begin
						state_q <= H_STOP;
						nack_q <= !ack_ok_q;
					end
				end
				H_MSTOP: begin
					if (elem_end) begin
						state_q <= H_START;
					end
				end
				H_READ: begin
					if (elem_end) begin
						rdata_q[{byte_q, 3'h0} +: 8] <= rx_q;
						byte_q <= byte_q + 2'h1;
						if (byte_q == len_q) begin
							state_q <= H_STOP;
						end
					end
				end
				H_STOP: begin
					if (elem_end) begin
						state_q <= H_IDLE;
						done_q <= 1'b1;
					end
				end
			endcase
		end
	end

	// Open-drain pins, driven only when low
	assign bus.host_scl_o = 1'b0;
	assign bus.host_sda_o = 1'b0;
	assign bus.host_scl_oe = !scl_hi_q;
	assign bus.host_sda_oe = !sda_hi_q;
endmodule : pxs_host

// ===== pxs_assertions.sv
// Purpose: Bus and standby checks beside the two-wire link
// Assumes: scl is driven by the host only
// Notes: Line run lengths counted in helper logic
`timescale 1ns/100ps
// ****************************************
// Checker
// ****************************************
module pxs_assertions #(
	parameter int QUARTER = 8
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic host_sda_oe,
	input wire logic dev_sda_oe,
	input wire logic scl,
	input wire logic sda,
	input wire logic measure_req,
	input wire logic standby,
	input wire logic led_sink_en
);
	logic scl_q;
	logic [15:0] run_q;
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	// Cycles since scl last changed, saturating
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			scl_q <= 1'b1;
			run_q <= 16'h0000;
		end else begin
			scl_q <= scl;
			run_q <= (scl != scl_q) ? 16'h0001 : run_q + {15'h0000, run_q != 16'hFFFF};
		end
	end

	// Start and stop seen on the wires
	sequence s_start;
		scl && $past(scl) && $fell(sda);
	endsequence
	sequence s_stop;
		scl && $past(scl) && $rose(sda);
	endsequence

	property p_idle_standby;
		!measure_req |=> standby && !led_sink_en;
	endproperty
	a_idle_standby: assert property (p_idle_standby) else $error("no standby while idle");
	property p_measure;
		measure_req ##1 measure_req |-> !standby && led_sink_en;
	endproperty
	a_measure: assert property (p_measure) else $error("standby while measuring");
	property p_sink_off;
		standby |-> !led_sink_en;
	endproperty
	a_sink_off: assert property (p_sink_off) else $error("emitter sink on in standby");
	property p_dev_hold;
		scl && $past(scl) |-> $stable(dev_sda_oe);
	endproperty
	a_dev_hold: assert property (p_dev_hold) else $error("device sda moved with scl high");
	property p_dev_slot;
		$changed(dev_sda_oe) |-> !scl && run_q < QUARTER;
	endproperty
	a_dev_slot: assert property (p_dev_slot) else $error("device sda change late");
	property p_start;
		s_start |-> host_sda_oe && !dev_sda_oe;
	endproperty
	a_start: assert property (p_start) else $error("start not made by host");
	property p_stop;
		s_stop |-> $past(host_sda_oe) && !$past(dev_sda_oe);
	endproperty
	a_stop: assert property (p_stop) else $error("stop not made by host");
	property p_scl_high;
		$fell(scl) |-> run_q >= 2 * QUARTER;
	endproperty
	a_scl_high: assert property (p_scl_high) else $error("scl high phase short");
	property p_scl_low;
		$rose(scl) |-> run_q >= 2 * QUARTER;
	endproperty
	a_scl_low: assert property (p_scl_low) else $error("scl low phase short");
endmodule : pxs_assertions

// ===== pxs_tb.sv
// Purpose: Host controller and sensor slave joined on one bus
// Assumes: APB driven just after pclk rising edges
// Notes: Short scl quarter keeps the run brief
`timescale 1ns/100ps
// ****************************************
// Testbench
// ****************************************
module pxs_tb;
	localparam int Q = 8;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic measure_req, standby, led_sink_en;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [15:0] prox_result;
	logic [7:0] ambient_ir, led_current;
	int n_mismatch;
	int tests_run;

	// Both ends on one bus, checker beside it
	pxs_i2c_if bus ();
	pxs_host #(.QUARTER(Q)) pxs_host_inst (.pclk(pclk), .presetn(presetn), .clk_en(1'b1),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .bus(bus.host));
	pxs_device pxs_device_inst (.pclk(pclk), .presetn(presetn), .clk_en(1'b1),
		.bus(bus.device), .measure_req(measure_req), .prox_result(prox_result),
		.ambient_ir(ambient_ir), .standby(standby), .led_sink_en(led_sink_en),
		.led_current(led_current));
	pxs_assertions #(.QUARTER(Q)) pxs_assertions_inst (.pclk(pclk), .presetn(presetn),
		.host_sda_oe(bus.host_sda_oe), .dev_sda_oe(bus.dev_sda_oe), .scl(bus.scl),
		.sda(bus.sda), .measure_req(measure_req), .standby(standby),
		.led_sink_en(led_sink_en));

	// Clock
	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end

	// Verdict and end of run
	task automatic summarize();
		$display("checks %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : summarize

	// One comparison
	task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected %s expected %h seen %h", nm, exp, got);
		end
	endtask : check

	// One APB transfer, waiting on pready
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
		output logic [31:0] rd, output logic err);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		err = pslverr;
		if (n >= 20) begin
			n_mismatch++;
			summarize();
		end
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb

	// Command word
	function automatic logic [31:0] mk(input logic [7:0] r, input logic [7:0] w,
		input logic [1:0] len, input logic [2:0] f);
		return {11'h000, f, len, w, r};
	endfunction : mk

	// Poll until done, then fetch read data
	task automatic wait_done(output logic [31:0] rd, output logic [31:0] st);
		logic e;
		int n;
		n = 0;
		st = 32'h00000000;
		while (st[pxs_pkg::ST_DONE_BIT] !== 1'b1) begin
			if (n++ > 3000) begin
				n_mismatch++;
				summarize();
			end
			apb(1'b0, pxs_pkg::APB_STATUS, 32'h00000000, st, e);
		end
		apb(1'b0, pxs_pkg::APB_RDATA, 32'h00000000, rd, e);
	endtask : wait_done

	// Issue a command and wait for it
	task automatic run_cmd(input logic [31:0] c, output logic [31:0] rd);
		logic [31:0] st;
		logic e;
		apb(1'b1, pxs_pkg::APB_CMD, c, rd, e);
		wait_done(rd, st);
		check("nack", 32'h00000000, {31'h0, st[pxs_pkg::ST_NACK_BIT]});
	endtask : run_cmd

	// Standby follows measurement demand
	task automatic t_standby();
		@(negedge pclk);
		check("current", 32'h00000000, {24'h000000, led_current});
		check("standby", 32'h1, {31'h0, standby});
		@(posedge pclk);
		measure_req <= 1'b1;
		repeat (2) @(negedge pclk);
		check("standby", 32'h0, {31'h0, standby});
		check("sink", 32'h1, {31'h0, led_sink_en});
		@(posedge pclk);
		measure_req <= 1'b0;
		repeat (2) @(negedge pclk);
		check("sink", 32'h0, {31'h0, led_sink_en});
		check("standby", 32'h1, {31'h0, standby});
		@(posedge pclk);
		$display("test standby done");
	endtask : t_standby

	// Register writes, timing default, burst read
	task automatic t_regs();
		logic [31:0] d;
		run_cmd(mk(8'h8F, 8'hA0, 2'h0, 3'h1), d);
		run_cmd(mk(8'h8F, 8'h00, 2'h0, 3'h0), d);
		check("timing", 32'h000000A0, d);
		run_cmd(mk(8'h00, 8'h00, 2'h0, 3'h4), d);
		run_cmd(mk(8'h8F, 8'h00, 2'h0, 3'h0), d);
		check("timing", 32'h00000001, d);
		run_cmd(mk(8'h83, 8'h5A, 2'h0, 3'h1), d);
		check("current", 32'h0000005A, {24'h000000, led_current});
		check("sink", 32'h0, {31'h0, led_sink_en});
		run_cmd(mk(8'h82, 8'h00, 2'h3, 3'h0), d);
		check("burst", 32'h00005A00, d);
		$display("test registers done");
	endtask : t_regs

	// Result bytes with stop and with repeated start
	task automatic t_result();
		logic [31:0] d;
		for (int i = 0; i < 2; i++) begin
			run_cmd(mk(8'h87, 8'h00, 2'h1, {1'b0, i[0], 1'b0}), d);
			check("result", 32'h00003CA5, d);
		end
		run_cmd(mk(8'h88, 8'h00, 2'h0, 3'h1), d);
		check("low byte", 32'h00000000, d);
		run_cmd(mk(8'h88, 8'h00, 2'h0, 3'h0), d);
		check("low byte", 32'h0000003C, d);
		$display("test result done");
	endtask : t_result

	// Refusals and unmapped offset
	task automatic t_refuse();
		logic [31:0] d;
		logic [31:0] st;
		logic e;
		apb(1'b1, pxs_pkg::APB_CMD, mk(8'h90, 8'h00, 2'h0, 3'h0), d, e);
		apb(1'b0, pxs_pkg::APB_STATUS, 32'h00000000, st, e);
		check("refused", 32'h00000008, st & 32'h00000009);
		check("scl", 32'h1, {31'h0, bus.scl});
		apb(1'b1, pxs_pkg::APB_STATUS, 32'h0000000E, d, e);
		apb(1'b1, pxs_pkg::APB_CMD, mk(8'h87, 8'h00, 2'h1, 3'h0), d, e);
		apb(1'b1, pxs_pkg::APB_CMD, mk(8'h83, 8'h00, 2'h0, 3'h0), d, e);
		wait_done(d, st);
		check("busy refused", 32'h00000008, st & 32'h00000008);
		check("result", 32'h00003CA5, d);
		apb(1'b0, 12'h00C, 32'h00000000, d, e);
		check("unmapped err", 32'h1, {31'h0, e});
		check("unmapped data", 32'h00000000, d);
		$display("test refusal done");
	endtask : t_refuse

	// Main sequence
	initial begin
		n_mismatch = 0;
		tests_run = 0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h00000000;
		measure_req = 1'b0;
		prox_result = 16'hA53C;
		ambient_ir = 8'h6E;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_standby();
		t_regs();
		t_result();
		t_refuse();
		summarize();
	end
endmodule : pxs_tb
